/* pkg/slrw_map.svh */
// Constants for the log read and write command handler.
`ifndef SLRW_MAP_SVH
`define SLRW_MAP_SVH
`define SLRW_CMD_SMART      8'hB0
`define SLRW_FEAT_READ_LOG  8'hD5
`define SLRW_FEAT_WRITE_LOG 8'hD6
`define SLRW_FEAT_ENABLE    8'hD8
`define SLRW_FEAT_DISABLE   8'hD9
`define SLRW_SIGNATURE      16'hC24F
`define SLRW_LOG_DIR        8'h00
`define SLRW_LOG_SUMMARY    8'h01
`define SLRW_LOG_EXT_ERR    8'h03
`define SLRW_LOG_SELFTEST   8'h06
`define SLRW_LOG_EXT_SELF   8'h07
`define SLRW_LOG_SELECTIVE  8'h09
`define SLRW_LOG_HOST_LO    8'h80
`define SLRW_LOG_HOST_HI    8'h9F
`define SLRW_LOG_INFO       8'hD9
`define SLRW_ST_FAULT_BIT   5
`define SLRW_ST_SENSE_BIT   1
`define SLRW_ST_ERR_BIT     0
`define SLRW_ER_ABORT_BIT   2
`define SLRW_ER_UNREC_BIT   6
`define SLRW_ER_CRC_BIT     7
`define SLRW_PAGE_WORDS     9'h100
`define SLRW_LAST_WORD      8'hFF
`define SLRW_PAGE_BITS      3
`define SLRW_NUM_SLOTS      4
`define SLRW_SLOT_SEL       2'h0
`define SLRW_SLOT_RO        2'h1
`define SLRW_SLOT_HOST      2'h2
`define SLRW_SLOT_INFO      2'h3
`define SLRW_SMART_ON_RST   1'b1
`endif

/* pkg/slrw_pkg.sv */
// Types shared by both ends of the log read and write handler.
package slrw_pkg;
   typedef enum logic [2:0] {
      SLRW_IDLE  = 3'b000,
      SLRW_CHECK = 3'b001,
      SLRW_READ  = 3'b010,
      SLRW_WRITE = 3'b011,
      SLRW_DONE  = 3'b100
   } slrw_state_t;
   typedef enum logic [1:0] {
      SLRW_H_IDLE = 2'b00,
      SLRW_H_ISSUE = 2'b01,
      SLRW_H_DATA = 2'b10,
      SLRW_H_WAIT = 2'b11
   } slrw_hstate_t;
endpackage : slrw_pkg

/* pkg/slrw_if.sv */
// Command, data and completion link between host controller and drive handler.
`timescale 1ns/100ps
`default_nettype none
interface slrw_if;
   logic        cmd_valid;
   logic [7:0]  command;
   logic [7:0]  feature;
   logic [7:0]  count;
   logic [27:0] lba;
   logic        cmd_ready;
   logic        wr_valid;
   logic [15:0] wr_data;
   logic        wr_ready;
   logic        rd_valid;
   logic [15:0] rd_data;
   logic        rd_ready;
   logic        done;
   logic [7:0]  status;
   logic [7:0]  error;
   modport dev (input cmd_valid, command, feature, count, lba, wr_valid, wr_data, rd_ready,
                output cmd_ready, wr_ready, rd_valid, rd_data, done, status, error);
   modport host (output cmd_valid, command, feature, count, lba, wr_valid, wr_data, rd_ready,
                 input cmd_ready, wr_ready, rd_valid, rd_data, done, status, error);
endinterface : slrw_if
`default_nettype wire

/* design/slrw_log_ram.sv */
// Word store for the writable and readable logs, one page per slot.
`timescale 1ns/100ps
`default_nettype none
`include "slrw_map.svh"
module slrw_log_ram
   import slrw_pkg::*;
(
   input  wire logic        mclk_in,    // Clock.
   input  wire logic        we_in,      // Write strobe.
   input  wire logic [9:0]  addr_in,    // Slot and word address.
   input  wire logic [15:0] wdata_in,   // Write word.
   output logic      [15:0] rdata_out   // Read word, one cycle after address.
);
   // Only one page per slot is kept; later pages of a read repeat it, later pages of a write overwrite it.
   logic [15:0] mem [0:1023];
   always_ff @(posedge mclk_in) begin
      if (we_in) begin
         mem[addr_in] <= wdata_in;
      end
      rdata_out <= mem[addr_in];
   end
endmodule : slrw_log_ram
`default_nettype wire

/* design/slrw_device.sv */
// Drive end: decodes and runs the log read and log write subcommands.
// Functional notes
// - B0h with D5h reads a log
// - B0h with D6h writes 512-byte blocks
// - Host puts C24Fh signature, selector low
// - Read count gives pages to transfer
// - Read always starts at first page
// - Each page is 512 bytes
// - Decode known selectors and their access
// - Selectors 03h and 07h abort
// - Write selector sits in LBA low
// - Write to read-only log aborts
// - Write stores from first block on
// - Write with zero count aborts
// - Error status and error bit layout
// - SMART disabled aborts all but enable
`timescale 1ns/100ps
`default_nettype none
`include "slrw_map.svh"
module slrw_device
   import slrw_pkg::*;
(
   input  wire logic mclk_in,          // 10 MHz clock.
   input  wire logic srst_in,          // Synchronous reset, active high.
   input  wire logic fault_in,         // Drive fault level from the engine.
   input  wire logic crc_err_in,       // Link CRC error seen during this command.
   input  wire logic unrec_in,         // Media read could not be recovered.
   output logic      smart_on_out,     // SMART operations enabled.
   slrw_if.dev       link              // Host link.
);
   slrw_state_t state_reg, state_next;
   logic        smart_reg, smart_next;
   logic [7:0]  feat_reg, feat_next;
   logic [7:0]  sel_reg, sel_next;
   logic [7:0]  pages_reg, pages_next;
   logic [7:0]  word_reg, word_next;
   logic [7:0]  status_reg, status_next;
   logic [7:0]  error_reg, error_next;
   logic        done_reg, done_next;
   logic        rvalid_reg, rvalid_next;
   logic [1:0]  slot;
   logic        known, writable, ext_log, abort_c;
   logic        we;
   logic [9:0]  ram_addr;
   logic [15:0] ram_q;

   // ==========================================================
   // Selector decode.
   always_comb begin
      known    = 1'b1;
      writable = 1'b0;
      slot     = `SLRW_SLOT_RO;
      ext_log  = (sel_reg == `SLRW_LOG_EXT_ERR) || (sel_reg == `SLRW_LOG_EXT_SELF);
      if (sel_reg == `SLRW_LOG_SELECTIVE) begin
         writable = 1'b1;
         slot     = `SLRW_SLOT_SEL;
      end else if (sel_reg >= `SLRW_LOG_HOST_LO && sel_reg <= `SLRW_LOG_HOST_HI) begin
         writable = 1'b1;
         slot     = `SLRW_SLOT_HOST;
      end else if (sel_reg == `SLRW_LOG_INFO) begin
         slot = `SLRW_SLOT_INFO;
      end else if (sel_reg != `SLRW_LOG_DIR && sel_reg != `SLRW_LOG_SUMMARY &&
                   sel_reg != `SLRW_LOG_SELFTEST) begin
         known = 1'b0;
      end
      abort_c = !smart_reg || ext_log || !known;
      if (feat_reg == `SLRW_FEAT_WRITE_LOG) begin
         abort_c = abort_c || !writable || (pages_reg == 8'h00);
      end
   end

   // Host-specific logs share one slot; read-only logs 00h, 01h and 06h share one image, D9h has its own.
   assign ram_addr = {slot, word_reg};
   assign we       = (state_reg == SLRW_WRITE) && link.wr_valid;

   slrw_log_ram u_ram (
      .mclk_in   (mclk_in),
      .we_in     (we),
      .addr_in   (ram_addr),
      .wdata_in  (link.wr_data),
      .rdata_out (ram_q)
   );

   // ==========================================================
   // Command sequencer.
   always_comb begin
      state_next  = state_reg;
      smart_next  = smart_reg;
      feat_next   = feat_reg;
      sel_next    = sel_reg;
      pages_next  = pages_reg;
      word_next   = word_reg;
      status_next = status_reg;
      error_next  = error_reg;
      done_next   = 1'b0;
      rvalid_next = rvalid_reg;
      case (state_reg)
         SLRW_IDLE: begin
            if (link.cmd_valid) begin
               feat_next   = link.feature;
               sel_next    = link.lba[7:0];
               pages_next  = link.count;
               word_next   = 8'h00;
               status_next = 8'h00;
               error_next  = 8'h00;
               state_next  = SLRW_DONE;
               if (link.command != `SLRW_CMD_SMART ||
                   link.lba[23:8] != `SLRW_SIGNATURE) begin
                  status_next[`SLRW_ST_ERR_BIT]   = 1'b1;
                  error_next[`SLRW_ER_ABORT_BIT] = 1'b1;
               end else if (link.feature == `SLRW_FEAT_ENABLE) begin
                  smart_next = 1'b1;
               end else if (!smart_reg) begin
                  status_next[`SLRW_ST_ERR_BIT]   = 1'b1;
                  error_next[`SLRW_ER_ABORT_BIT] = 1'b1;
               end else if (link.feature == `SLRW_FEAT_DISABLE) begin
                  smart_next = 1'b0;
               end else if (link.feature == `SLRW_FEAT_READ_LOG ||
                            link.feature == `SLRW_FEAT_WRITE_LOG) begin
                  state_next = SLRW_CHECK;
               end else begin
                  status_next[`SLRW_ST_ERR_BIT]   = 1'b1;
                  error_next[`SLRW_ER_ABORT_BIT] = 1'b1;
               end
            end
         end
         SLRW_CHECK: begin
            if (abort_c) begin
               status_next[`SLRW_ST_ERR_BIT]   = 1'b1;
               error_next[`SLRW_ER_ABORT_BIT] = 1'b1;
               state_next = SLRW_DONE;
            end else if (feat_reg == `SLRW_FEAT_WRITE_LOG) begin
               state_next = SLRW_WRITE;
            end else if (pages_reg == 8'h00) begin
               state_next = SLRW_DONE;
            end else begin
               state_next = SLRW_READ;
            end
         end
         SLRW_READ: begin
            // One cycle of RAM latency: the word is presented after the address settles.
            if (!rvalid_reg) begin
               rvalid_next = 1'b1;
            end else if (link.rd_ready) begin
               rvalid_next = 1'b0;
               word_next   = word_reg + 8'h01;
               if (word_reg == `SLRW_LAST_WORD) begin
                  pages_next = pages_reg - 8'h01;
                  if (pages_reg == 8'h01) begin
                     state_next = SLRW_DONE;
                  end
               end
            end
         end
         SLRW_WRITE: begin
            if (link.wr_valid) begin
               word_next = word_reg + 8'h01;
               if (word_reg == `SLRW_LAST_WORD) begin
                  pages_next = pages_reg - 8'h01;
                  if (pages_reg == 8'h01) begin
                     state_next = SLRW_DONE;
                  end
               end
            end
         end
         SLRW_DONE: begin
            status_next[`SLRW_ST_FAULT_BIT] = fault_in;
            if (fault_in || crc_err_in || unrec_in) begin
               status_next[`SLRW_ST_ERR_BIT] = 1'b1;
            end
            error_next[`SLRW_ER_CRC_BIT] = crc_err_in;
            if (feat_reg == `SLRW_FEAT_READ_LOG) begin
               error_next[`SLRW_ER_UNREC_BIT] = unrec_in;
            end
            done_next  = 1'b1;
            state_next = SLRW_IDLE;
         end
         default: begin
            state_next = SLRW_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state_reg  <= SLRW_IDLE;
         smart_reg  <= `SLRW_SMART_ON_RST;
         feat_reg   <= 8'h00;
         sel_reg    <= 8'h00;
         pages_reg  <= 8'h00;
         word_reg   <= 8'h00;
         status_reg <= 8'h00;
         error_reg  <= 8'h00;
         done_reg   <= 1'b0;
         rvalid_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         smart_reg  <= smart_next;
         feat_reg   <= feat_next;
         sel_reg    <= sel_next;
         pages_reg  <= pages_next;
         word_reg   <= word_next;
         status_reg <= status_next;
         error_reg  <= error_next;
         done_reg   <= done_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // ==========================================================
   // Link outputs.
   assign link.cmd_ready = (state_reg == SLRW_IDLE);
   assign link.wr_ready  = (state_reg == SLRW_WRITE);
   assign link.rd_valid  = (state_reg == SLRW_READ) && rvalid_reg;
   assign link.rd_data   = ram_q;
   assign link.done      = done_reg;
   assign link.status    = status_reg;
   assign link.error     = error_reg;
   assign smart_on_out   = smart_reg;
endmodule : slrw_device
`default_nettype wire

/* design/slrw_host.sv */
// Host end: issues one log command and moves its pages over the link.
`timescale 1ns/100ps
`default_nettype none
`include "slrw_map.svh"
module slrw_host
   import slrw_pkg::*;
(
   input  wire logic        mclk_in,     // 10 MHz clock.
   input  wire logic        srst_in,     // Synchronous reset, active high.
   input  wire logic        start_in,    // Pulse: issue a command.
   input  wire logic [7:0]  feature_in,  // Subcommand feature code.
   input  wire logic [7:0]  log_sel_in,  // Log selector.
   input  wire logic [7:0]  count_in,    // Page count.
   input  wire logic        wvalid_in,   // User write word valid.
   input  wire logic [15:0] wdata_in,    // User write word.
   output logic             wready_out,  // User write word taken.
   output logic             rvalid_out,  // Read word valid, one cycle.
   output logic      [15:0] rdata_out,   // Read word.
   output logic             busy_out,    // Command in progress.
   output logic             done_out,    // Completion pulse.
   output logic      [7:0]  status_out,  // Completion status.
   output logic      [7:0]  error_out,   // Completion error.
   slrw_if.host             link         // Drive link.
);
   slrw_hstate_t state_reg, state_next;
   logic [7:0]   feat_reg, feat_next, sel_reg, sel_next, cnt_reg, cnt_next;
   logic [15:0]  rdata_reg, rdata_next;
   logic         rvalid_reg, rvalid_next, done_reg, done_next;
   logic [7:0]   st_reg, st_next, er_reg, er_next;

   // ==========================================================
   always_comb begin
      state_next  = state_reg;
      feat_next   = feat_reg;
      sel_next    = sel_reg;
      cnt_next    = cnt_reg;
      rdata_next  = rdata_reg;
      rvalid_next = 1'b0;
      done_next   = 1'b0;
      st_next     = st_reg;
      er_next     = er_reg;
      case (state_reg)
         SLRW_H_IDLE: begin
            if (start_in) begin
               feat_next  = feature_in;
               sel_next   = log_sel_in;
               cnt_next   = count_in;
               state_next = SLRW_H_ISSUE;
            end
         end
         SLRW_H_ISSUE: begin
            if (link.cmd_ready) begin
               state_next = SLRW_H_DATA;
            end
         end
         SLRW_H_DATA: begin
            if (link.rd_valid) begin
               rdata_next  = link.rd_data;
               rvalid_next = 1'b1;
            end
            if (link.done) begin
               st_next    = link.status;
               er_next    = link.error;
               done_next  = 1'b1;
               state_next = SLRW_H_IDLE;
            end
         end
         default: begin
            state_next = SLRW_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state_reg  <= SLRW_H_IDLE;
         feat_reg   <= 8'h00;
         sel_reg    <= 8'h00;
         cnt_reg    <= 8'h00;
         rdata_reg  <= 16'h0000;
         rvalid_reg <= 1'b0;
         done_reg   <= 1'b0;
         st_reg     <= 8'h00;
         er_reg     <= 8'h00;
      end else begin
         state_reg  <= state_next;
         feat_reg   <= feat_next;
         sel_reg    <= sel_next;
         cnt_reg    <= cnt_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
         done_reg   <= done_next;
         st_reg     <= st_next;
         er_reg     <= er_next;
      end
   end

   // ==========================================================
   assign link.cmd_valid = (state_reg == SLRW_H_ISSUE);
   assign link.command   = `SLRW_CMD_SMART;
   assign link.feature   = feat_reg;
   assign link.count     = cnt_reg;
   assign link.lba       = {4'h0, `SLRW_SIGNATURE, sel_reg};
   assign link.wr_valid  = (state_reg == SLRW_H_DATA) && wvalid_in;
   assign link.wr_data   = wdata_in;
   assign link.rd_ready  = (state_reg == SLRW_H_DATA);
   assign wready_out     = (state_reg == SLRW_H_DATA) && link.wr_ready;
   assign rvalid_out     = rvalid_reg;
   assign rdata_out      = rdata_reg;
   assign busy_out       = (state_reg != SLRW_H_IDLE);
   assign done_out       = done_reg;
   assign status_out     = st_reg;
   assign error_out      = er_reg;
endmodule : slrw_host
`default_nettype wire

/* sim/slrw_link_sva.sv */
// Assertion checker watching the command, data and completion link.
`timescale 1ns/100ps
`default_nettype none
`include "slrw_map.svh"
module slrw_link_sva (
   input wire logic        mclk_in,    // Clock.
   input wire logic        srst_in,    // Reset.
   input wire logic        cmd_valid,  // Command offered.
   input wire logic [7:0]  command,    // Command code.
   input wire logic [7:0]  feature,    // Feature code.
   input wire logic [7:0]  count,      // Page count.
   input wire logic [27:0] lba,        // Signature and selector.
   input wire logic        cmd_ready,  // Command accepted.
   input wire logic        wr_valid,   // Write word offered.
   input wire logic        wr_ready,   // Write word accepted.
   input wire logic        rd_valid,   // Read word offered.
   input wire logic        rd_ready,   // Read word accepted.
   input wire logic        done,       // Completion pulse.
   input wire logic [7:0]  status,     // Completion status.
   input wire logic [7:0]  error       // Completion error.
);
   logic        take;
   logic        ro_sel;
   logic        log_reg;
   logic        smart_reg;
   logic        idle_reg;
   logic [7:0]  cnt_reg;
   logic [16:0] words_reg;
   assign take   = cmd_valid && cmd_ready;
   assign ro_sel = lba[7:0] inside {8'h00, 8'h01, 8'h06, 8'hD9};
   // ==========================================================================
   // Helper state
   // The SMART switch is tracked here because the link does not carry it.
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         words_reg <= 17'h0_0000;
         cnt_reg   <= 8'h00;
         log_reg   <= 1'b0;
         smart_reg <= `SLRW_SMART_ON_RST;
      end else if (take) begin
         words_reg <= 17'h0_0000;
         cnt_reg   <= count;
         log_reg   <= feature inside {`SLRW_FEAT_READ_LOG, `SLRW_FEAT_WRITE_LOG};
         if (feature == `SLRW_FEAT_ENABLE) smart_reg <= 1'b1;
         if (feature == `SLRW_FEAT_DISABLE) smart_reg <= 1'b0;
      end else if ((wr_valid && wr_ready) || (rd_valid && rd_ready)) begin
         words_reg <= words_reg + 17'h0_0001;
      end
   end
   // Status and error may move while a command runs, so holding is only watched between
   // reset or the completion pulse and the next command taken.
   always_ff @(posedge mclk_in) begin
      if (srst_in || done) begin
         idle_reg <= 1'b1;
      end else if (take) begin
         idle_reg <= 1'b0;
      end
   end
   // ==========================================================================
   // Properties
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (srst_in);
   property p_cmd_form;
      cmd_valid |-> command == `SLRW_CMD_SMART && lba[23:8] == `SLRW_SIGNATURE;
   endproperty
   a_cmd_form: assert property (p_cmd_form) else $error("bad command form");
   property p_one_cmd;
      take |=> !cmd_ready;
   endproperty
   a_one_cmd: assert property (p_one_cmd) else $error("second command taken");
   property p_ro_write;
      take && feature == `SLRW_FEAT_WRITE_LOG && ro_sel
         |-> (!wr_ready) throughout (##[2:4] (done && error[2] && status[0]));
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write ran");
   property p_ext_abort;
      take && lba[7:0] inside {8'h03, 8'h07}
         && feature inside {`SLRW_FEAT_READ_LOG, `SLRW_FEAT_WRITE_LOG}
         |-> (!wr_ready && !rd_valid) throughout (##[2:4] (done && error[2]));
   endproperty
   a_ext_abort: assert property (p_ext_abort) else $error("extended log ran");
   property p_zero_write;
      take && feature == `SLRW_FEAT_WRITE_LOG && count == 8'h00 |=> ##[1:3] (done && error[2]);
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write ran");
   property p_read_start;
      take && smart_reg && feature == `SLRW_FEAT_READ_LOG && lba[7:0] == 8'h80
         && count != 8'h00 |-> ##[2:4] rd_valid;
   endproperty
   a_read_start: assert property (p_read_start) else $error("read did not start");
   property p_page_words;
      done && log_reg && !status[0] |-> words_reg == {1'b0, cnt_reg, 8'h00};
   endproperty
   a_page_words: assert property (p_page_words) else $error("page size wrong");
   property p_abort_nodata;
      done && error[2] |-> words_reg == 17'h0_0000 && status[0];
   endproperty
   a_abort_nodata: assert property (p_abort_nodata) else $error("abort moved data");
   property p_status_hold;
      (done || idle_reg) && !take |=> $stable(status) && $stable(error);
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status moved");
   c_read: cover property (done && log_reg && !status[0] && cnt_reg == 8'h02);
endmodule : slrw_link_sva
`default_nettype wire

/* sim/test_smart_log_read_write.sv */
// Bench joining host and drive ends, running log commands from a table.
`timescale 1ns/100ps
`default_nettype none
`include "slrw_map.svh"
module test_smart_log_read_write
   import slrw_pkg::*;
;
   // Row: feature, selector, count, data pattern, status, error, words moved.
   typedef struct packed {
      logic [7:0]  feat;
      logic [7:0]  sel;
      logic [7:0]  cnt;
      logic [7:0]  pat;
      logic [7:0]  st;
      logic [7:0]  er;
      logic [15:0] words;
   } slrw_row_t;
   // A pattern of FF marks a log whose contents are not fixed, so data is not compared.
   slrw_row_t   rows [29] = '{
      64'hD680_01A5_0000_0100, 64'hD609_015A_0000_0100, 64'hD580_02A5_0000_0200,
      64'hD509_015A_0000_0100, 64'hD69F_013C_0000_0100, 64'hD580_013C_0000_0100,
      64'hD580_0000_0000_0000, 64'hD609_0000_0104_0000, 64'hD509_015A_0000_0100,
      64'hD503_0100_0104_0000, 64'hD507_0100_0104_0000, 64'hD603_0100_0104_0000,
      64'hD607_0100_0104_0000, 64'hD600_0100_0104_0000, 64'hD601_0100_0104_0000,
      64'hD606_0100_0104_0000, 64'hD6D9_0100_0104_0000, 64'hD502_0100_0104_0000,
      64'hD500_01FF_0000_0100, 64'hD501_01FF_0000_0100, 64'hD506_01FF_0000_0100,
      64'hD5D9_01FF_0000_0100, 64'hD780_0100_0104_0000, 64'hD900_0000_0000_0000,
      64'hD580_0100_0104_0000, 64'hD680_0111_0104_0000, 64'hD900_0000_0104_0000,
      64'hD800_0000_0000_0000, 64'hD580_013C_0000_0100};
   logic        mclk_in, srst_in, start_in, wvalid_in, fault_in, crc_err_in, unrec_in;
   logic [7:0]  feature_in, log_sel_in, count_in, status_out, error_out, cur_pat, cur_sel;
   logic [15:0] wdata_in, rdata_out, wtk, rtk;
   logic        wready_out, rvalid_out, busy_out, done_out, smart_on_out;
   int          num_errors = 0;
   int          n_tests = 0;
   slrw_if slrw_if_inst ();
   slrw_device slrw_device_inst (.mclk_in(mclk_in), .srst_in(srst_in), .fault_in(fault_in),
      .crc_err_in(crc_err_in), .unrec_in(unrec_in), .smart_on_out(smart_on_out),
      .link(slrw_if_inst));
   slrw_host slrw_host_inst (.mclk_in(mclk_in), .srst_in(srst_in), .start_in(start_in),
      .feature_in(feature_in), .log_sel_in(log_sel_in), .count_in(count_in),
      .wvalid_in(wvalid_in), .wdata_in(wdata_in), .wready_out(wready_out),
      .rvalid_out(rvalid_out), .rdata_out(rdata_out), .busy_out(busy_out),
      .done_out(done_out), .status_out(status_out), .error_out(error_out),
      .link(slrw_if_inst));
   slrw_link_sva slrw_link_sva_inst (.mclk_in(mclk_in), .srst_in(srst_in),
      .cmd_valid(slrw_if_inst.cmd_valid), .command(slrw_if_inst.command),
      .feature(slrw_if_inst.feature), .count(slrw_if_inst.count), .lba(slrw_if_inst.lba),
      .cmd_ready(slrw_if_inst.cmd_ready), .wr_valid(slrw_if_inst.wr_valid),
      .wr_ready(slrw_if_inst.wr_ready), .rd_valid(slrw_if_inst.rd_valid),
      .rd_ready(slrw_if_inst.rd_ready), .done(slrw_if_inst.done),
      .status(slrw_if_inst.status), .error(slrw_if_inst.error));
   // ==========================================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      if (num_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   task automatic issue(input slrw_row_t r);
      repeat (2) @(posedge mclk_in);
      start_in   <= 1'b1;
      feature_in <= r.feat;
      log_sel_in <= r.sel;
      count_in   <= r.cnt;
      cur_pat    <= r.pat;
      cur_sel    <= r.sel;
      @(posedge mclk_in);
      start_in   <= 1'b0;
   endtask : issue
   task automatic finish(input slrw_row_t r);
      int i = 0;
      while (done_out !== 1'b1 && i < 2000) begin
         @(negedge mclk_in);
         i++;
      end
      if (i >= 2000) begin
         num_errors++;
         tally_and_finish();
      end
      check({24'h00_0000, status_out}, {24'h00_0000, r.st});
      check({24'h00_0000, error_out}, {24'h00_0000, r.er});
      check({16'h0000, wtk + rtk}, {16'h0000, r.words});
   endtask : finish
   // ==========================================================================
   // Word feed and link watch
   // The write word is held offered all the time; only the drive decides when it is taken.
   always @(posedge mclk_in) begin
      if (srst_in || start_in) begin
         wtk      <= 16'h0000;
         wdata_in <= {cur_pat, 8'h00};
      end else if (wvalid_in && wready_out) begin
         wtk      <= wtk + 16'h0001;
         wdata_in <= {cur_pat, wtk[7:0] + 8'h01};
      end
   end
   always @(negedge mclk_in) begin
      if (srst_in || start_in) begin
         rtk <= 16'h0000;
      end
      if (rvalid_out === 1'b1) begin
         if (cur_pat != 8'hFF) check({16'h0000, rdata_out}, {16'h0000, cur_pat, rtk[7:0]});
         rtk <= rtk + 16'h0001;
      end
      if (slrw_if_inst.cmd_valid === 1'b1) begin
         check({slrw_if_inst.command, slrw_if_inst.lba[23:0]}, {8'hB0, 16'hC24F, cur_sel});
      end
   end
   // ==========================================================================
   // Stimulus
   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end
   initial begin
      {srst_in, start_in, wvalid_in, fault_in, crc_err_in, unrec_in} = 6'h20;
      {feature_in, log_sel_in, count_in, cur_pat, cur_sel} = 40'h00_0000_0000;
      repeat (2) @(posedge mclk_in);
      srst_in   <= 1'b0;
      wvalid_in <= 1'b1;
      @(negedge mclk_in);
      check({busy_out, smart_on_out, slrw_if_inst.cmd_ready, status_out}, 32'h0000_0300);
      for (int k = 0; k < 29; k++) begin
         issue(rows[k]);
         finish(rows[k]);
      end
      // Faults seen at completion still let the page through but flag the status.
      {fault_in, crc_err_in, unrec_in} <= 3'h7;
      issue(64'hD580_013C_21C0_0100);
      finish(64'hD580_013C_21C0_0100);
      {fault_in, crc_err_in, unrec_in} <= 3'h0;
      // Reset in the middle of a two-page read; the next read must start afresh.
      issue(64'hD580_023C_0000_0200);
      repeat (60) @(posedge mclk_in);
      srst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      srst_in <= 1'b0;
      @(negedge mclk_in);
      check({busy_out, smart_on_out, slrw_if_inst.cmd_ready, status_out}, 32'h0000_0300);
      issue(64'hD580_013C_0000_0100);
      finish(64'hD580_013C_0000_0100);
      issue(64'hD900_0000_0000_0000);
      finish(64'hD900_0000_0000_0000);
      check({31'h0000_0000, smart_on_out}, 32'h0000_0000);
      tally_and_finish();
   end
endmodule : test_smart_log_read_write
`default_nettype wire
